// file: hw/adc_clock_cfg.sv
// clock tree configuration registers and divider chain of an audio adc
// assumes a paged register port already decoded from the control bus
//
// How it works
// - integer multiplier is six bits, 1..63, zero reserved, resets to four.
// - fraction is 14 bits, six high and eight low, both reset zero.
// - a fraction high write only applies when fraction low follows next.
// - converter divider bit 7 is its power bit, reset off.
// - converter divider code divides by code, zero means 128, reset one.
// - modulator divider bit 7 is its power bit, reset off.
// - modulator divider code divides by code, zero means 128, reset one.
// - oversampling ratio 1..255, zero means 256, resets to 128.
// - instruction count is two per code step, up to 510, zero reserved.
// - decimation 1..15, zero means 16, resets to four.
// - pre-divider register bit 7 powers the synthesizer, reset off.
// - pre-divider zero means eight, multiplier r zero means sixteen.
// - converter source is master clock, bit clock or synthesizer output.
module adc_clock_cfg
  import adc_clock_cfg_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // clock sources, sampled as levels
  input wire logic mclk_i,
  input wire logic bclk_i,
  input wire logic synth_clk_i,
  // synthesizer settings
  output logic synth_power_o,
  output logic [3:0] synth_pre_div_o,
  output logic [4:0] synth_mult_r_o,
  output logic [5:0] synth_int_o,
  output logic [13:0] synth_frac_o,
  // derived clock ticks
  output logic converter_clock_tick_o,
  output logic modulator_clock_tick_o,
  output logic sample_tick_o,
  // signal processor settings
  output logic [8:0] oversampling_ratio_o,
  output logic [8:0] dsp_instruction_count_o,
  output logic [4:0] dsp_decimation_o
);

  // reset release
  logic rst_meta_q;
  logic rst_sync_q;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // register state
  logic [7:0] page_q, page_d;
  logic [3:0] clk_mux_q, clk_mux_d;
  logic [7:0] synth_pr_q, synth_pr_d;
  logic [5:0] synth_int_q, synth_int_d;
  logic [5:0] frac_high_q, frac_high_d;
  logic [5:0] frac_stage_q, frac_stage_d;
  logic frac_pend_q, frac_pend_d;
  logic [7:0] frac_low_q, frac_low_d;
  logic [7:0] conv_div_q, conv_div_d;
  logic [7:0] mod_div_q, mod_div_d;
  logic [7:0] osr_q, osr_d;
  logic [7:0] instr_q, instr_d;
  logic [3:0] decim_q, decim_d;
  logic [7:0] rdata_q, rdata_d;
  logic on_page0;

  assign on_page0 = (page_q == 8'h00);

  always_comb begin
    page_d = page_q;
    clk_mux_d = clk_mux_q;
    synth_pr_d = synth_pr_q;
    synth_int_d = synth_int_q;
    frac_high_d = frac_high_q;
    frac_stage_d = frac_stage_q;
    frac_pend_d = frac_pend_q;
    frac_low_d = frac_low_q;
    conv_div_d = conv_div_q;
    mod_div_d = mod_div_q;
    osr_d = osr_q;
    instr_d = instr_q;
    decim_d = decim_q;
    rdata_d = rdata_q;
    if (reg_wr_i) begin
      // any access ends the fraction high staging window
      frac_pend_d = 1'b0;
      if (reg_addr_i == ADDR_PAGE) begin
        page_d = reg_wdata_i;
      end else if (on_page0) begin
        case (reg_addr_i)
          ADDR_CLK_MUX: clk_mux_d = reg_wdata_i[3:0];
          ADDR_SYNTH_PR: synth_pr_d = reg_wdata_i;
          // upper bits dropped rather than stored
          ADDR_SYNTH_INT: synth_int_d = reg_wdata_i[5:0];
          ADDR_FRAC_HIGH: begin
            frac_stage_d = reg_wdata_i[5:0];
            frac_pend_d = 1'b1;
          end
          ADDR_FRAC_LOW: begin
            frac_low_d = reg_wdata_i;
            if (frac_pend_q) begin
              frac_high_d = frac_stage_q;
            end
          end
          ADDR_CONV_DIV: conv_div_d = reg_wdata_i;
          ADDR_MOD_DIV: mod_div_d = reg_wdata_i;
          ADDR_OSR: osr_d = reg_wdata_i;
          ADDR_INSTR_CNT: instr_d = reg_wdata_i;
          // upper four bits are read-only zero
          ADDR_DECIM: decim_d = reg_wdata_i[3:0];
          default: ;
        endcase
      end
      // self-clearing software reset of control registers
      if (on_page0 && reg_addr_i == ADDR_SW_RESET &&
          reg_wdata_i[SW_RESET_BIT]) begin
        page_d = RST_PAGE;
        clk_mux_d = RST_CLK_MUX;
        synth_pr_d = RST_SYNTH_PR;
        synth_int_d = RST_SYNTH_INT;
        frac_high_d = RST_FRAC_HIGH;
        frac_stage_d = RST_FRAC_HIGH;
        frac_low_d = RST_FRAC_LOW;
        conv_div_d = RST_CONV_DIV;
        mod_div_d = RST_MOD_DIV;
        osr_d = RST_OSR;
        instr_d = RST_INSTR_CNT;
        decim_d = RST_DECIM;
      end
    end else if (reg_rd_i) begin
      frac_pend_d = 1'b0;
      rdata_d = 8'h00;
      if (reg_addr_i == ADDR_PAGE) begin
        rdata_d = page_q;
      end else if (on_page0) begin
        case (reg_addr_i)
          ADDR_CLK_MUX: rdata_d = {4'h0, clk_mux_q};
          ADDR_SYNTH_PR: rdata_d = synth_pr_q;
          ADDR_SYNTH_INT: rdata_d = {2'b00, synth_int_q};
          ADDR_FRAC_HIGH: rdata_d = {2'b00, frac_high_q};
          ADDR_FRAC_LOW: rdata_d = frac_low_q;
          ADDR_CONV_DIV: rdata_d = conv_div_q;
          ADDR_MOD_DIV: rdata_d = mod_div_q;
          ADDR_OSR: rdata_d = osr_q;
          ADDR_INSTR_CNT: rdata_d = instr_q;
          ADDR_DECIM: rdata_d = {4'h0, decim_q};
          default: rdata_d = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      page_q <= RST_PAGE;
      clk_mux_q <= RST_CLK_MUX;
      synth_pr_q <= RST_SYNTH_PR;
      synth_int_q <= RST_SYNTH_INT;
      frac_high_q <= RST_FRAC_HIGH;
      frac_stage_q <= RST_FRAC_HIGH;
      frac_pend_q <= 1'b0;
      frac_low_q <= RST_FRAC_LOW;
      conv_div_q <= RST_CONV_DIV;
      mod_div_q <= RST_MOD_DIV;
      osr_q <= RST_OSR;
      instr_q <= RST_INSTR_CNT;
      decim_q <= RST_DECIM;
      rdata_q <= 8'h00;
    end else begin
      page_q <= page_d;
      clk_mux_q <= clk_mux_d;
      synth_pr_q <= synth_pr_d;
      synth_int_q <= synth_int_d;
      frac_high_q <= frac_high_d;
      frac_stage_q <= frac_stage_d;
      frac_pend_q <= frac_pend_d;
      frac_low_q <= frac_low_d;
      conv_div_q <= conv_div_d;
      mod_div_q <= mod_div_d;
      osr_q <= osr_d;
      instr_q <= instr_d;
      decim_q <= decim_d;
      rdata_q <= rdata_d;
    end
  end

  // decoded settings, registered from next values so they track the regs
  logic synth_power_q;
  logic [3:0] pre_div_q;
  logic [4:0] mult_r_q;
  logic [8:0] osr_out_q;
  logic [8:0] instr_out_q;
  logic [4:0] decim_out_q;
  always_ff @(posedge core_clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      synth_power_q <= 1'b0;
      pre_div_q <= 4'h1;
      mult_r_q <= 5'h01;
      osr_out_q <= 9'h080;
      instr_out_q <= 9'h100;
      decim_out_q <= 5'h04;
    end else begin
      synth_power_q <= synth_pr_d[POWER_BIT];
      pre_div_q <= div3(synth_pr_d[PRE_DIV_LSB +: 3]);
      mult_r_q <= div4(synth_pr_d[MULT_R_LSB +: 4]);
      osr_out_q <= div8(osr_d);
      // two instructions per code step, zero left as reserved zero
      instr_out_q <= {instr_d, 1'b0};
      decim_out_q <= div4(decim_d);
    end
  end

  // source edge detection; inputs are synchronous levels
  logic mclk_q, bclk_q, synth_clk_q;
  logic src_tick_q, src_tick_d;
  always_comb begin
    case (clk_mux_q[1:0])
      SRC_MCLK: src_tick_d = mclk_i & ~mclk_q;
      SRC_BCLK: src_tick_d = bclk_i & ~bclk_q;
      SRC_SYNTH: src_tick_d = synth_clk_i & ~synth_clk_q & synth_power_q;
      default: src_tick_d = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      mclk_q <= 1'b0;
      bclk_q <= 1'b0;
      synth_clk_q <= 1'b0;
      src_tick_q <= 1'b0;
    end else begin
      mclk_q <= mclk_i;
      bclk_q <= bclk_i;
      synth_clk_q <= synth_clk_i;
      src_tick_q <= src_tick_d;
    end
  end

  // divider chain
  logic conv_tick;
  logic mod_tick;
  clock_div_stage u_conv_div (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_sync_q),
    .power_i(conv_div_q[POWER_BIT]),
    .code_i(conv_div_q[6:0]),
    .tick_i(src_tick_q),
    .tick_o(conv_tick)
  );

  clock_div_stage u_mod_div (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_sync_q),
    .power_i(mod_div_q[POWER_BIT]),
    .code_i(mod_div_q[6:0]),
    .tick_i(conv_tick),
    .tick_o(mod_tick)
  );

  // sample rate counter over modulator ticks
  logic [8:0] osr_cnt_q, osr_cnt_d;
  logic sample_q, sample_d;
  logic conv_out_q, mod_out_q;
  always_comb begin
    osr_cnt_d = osr_cnt_q;
    sample_d = 1'b0;
    if (!mod_div_q[POWER_BIT]) begin
      osr_cnt_d = 9'h000;
    end else if (mod_tick) begin
      if (osr_cnt_q + 9'h001 >= osr_out_q) begin
        osr_cnt_d = 9'h000;
        sample_d = 1'b1;
      end else begin
        osr_cnt_d = osr_cnt_q + 9'h001;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      osr_cnt_q <= 9'h000;
      sample_q <= 1'b0;
      conv_out_q <= 1'b0;
      mod_out_q <= 1'b0;
    end else begin
      osr_cnt_q <= osr_cnt_d;
      sample_q <= sample_d;
      conv_out_q <= conv_tick;
      mod_out_q <= mod_tick;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign synth_power_o = synth_power_q;
  assign synth_pre_div_o = pre_div_q;
  assign synth_mult_r_o = mult_r_q;
  assign synth_int_o = synth_int_q;
  assign synth_frac_o = {frac_high_q, frac_low_q};
  assign converter_clock_tick_o = conv_out_q;
  assign modulator_clock_tick_o = mod_out_q;
  assign sample_tick_o = sample_q;
  assign oversampling_ratio_o = osr_out_q;
  assign dsp_instruction_count_o = instr_out_q;
  assign dsp_decimation_o = decim_out_q;

endmodule // adc_clock_cfg

// file: hw/adc_clock_cfg_pkg.sv
// constants for the audio converter clock configuration block
// assumes one core clock; register offsets are page 0 indexes
package adc_clock_cfg_pkg;

  // register offsets
  localparam logic [7:0] ADDR_PAGE = 8'h00;
  localparam logic [7:0] ADDR_SW_RESET = 8'h01;
  localparam logic [7:0] ADDR_CLK_MUX = 8'h04;
  localparam logic [7:0] ADDR_SYNTH_PR = 8'h05;
  localparam logic [7:0] ADDR_SYNTH_INT = 8'h06;
  localparam logic [7:0] ADDR_FRAC_HIGH = 8'h07;
  localparam logic [7:0] ADDR_FRAC_LOW = 8'h08;
  localparam logic [7:0] ADDR_CONV_DIV = 8'h12;
  localparam logic [7:0] ADDR_MOD_DIV = 8'h13;
  localparam logic [7:0] ADDR_OSR = 8'h14;
  localparam logic [7:0] ADDR_INSTR_CNT = 8'h15;
  localparam logic [7:0] ADDR_DECIM = 8'h16;

  // reset values
  localparam logic [7:0] RST_PAGE = 8'h00;
  localparam logic [3:0] RST_CLK_MUX = 4'h0;
  localparam logic [7:0] RST_SYNTH_PR = 8'h11;
  localparam logic [5:0] RST_SYNTH_INT = 6'h04;
  localparam logic [5:0] RST_FRAC_HIGH = 6'h00;
  localparam logic [7:0] RST_FRAC_LOW = 8'h00;
  localparam logic [7:0] RST_CONV_DIV = 8'h01;
  localparam logic [7:0] RST_MOD_DIV = 8'h01;
  localparam logic [7:0] RST_OSR = 8'h80;
  localparam logic [7:0] RST_INSTR_CNT = 8'h80;
  localparam logic [3:0] RST_DECIM = 4'h4;

  // field positions
  localparam int POWER_BIT = 7;
  localparam int SW_RESET_BIT = 0;
  localparam int PRE_DIV_LSB = 4;
  localparam int MULT_R_LSB = 0;

  // converter clock source codes
  localparam logic [1:0] SRC_MCLK = 2'h0;
  localparam logic [1:0] SRC_BCLK = 2'h1;
  localparam logic [1:0] SRC_SYNTH = 2'h3;

  // seven-bit divider code, zero means 128
  function automatic logic [7:0] div7(input logic [6:0] code);
    div7 = (code == 7'h00) ? 8'h80 : {1'b0, code};
  endfunction

  // three-bit pre-divider code, zero means 8
  function automatic logic [3:0] div3(input logic [2:0] code);
    div3 = (code == 3'h0) ? 4'h8 : {1'b0, code};
  endfunction

  // four-bit code, zero means 16
  function automatic logic [4:0] div4(input logic [3:0] code);
    div4 = (code == 4'h0) ? 5'h10 : {1'b0, code};
  endfunction

  // eight-bit code, zero means 256
  function automatic logic [8:0] div8(input logic [7:0] code);
    div8 = (code == 8'h00) ? 9'h100 : {1'b0, code};
  endfunction

endpackage

// file: hw/clock_div_stage.sv
// one divider stage with a power bit, emits a tick every n input ticks
// assumes input ticks are one-cycle pulses on the core clock
module clock_div_stage
  import adc_clock_cfg_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic power_i,
  input wire logic [6:0] code_i,
  // ticks
  input wire logic tick_i,
  output logic tick_o
);

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic tick_q;
  logic tick_d;

  always_comb begin
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (!power_i) begin
      cnt_d = 8'h00;
    end else if (tick_i) begin
      if (cnt_q + 8'h01 >= div7(code_i)) begin
        cnt_d = 8'h00;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;

endmodule // clock_div_stage

// file: tb/adc_clock_cfg_assertions.sv
// checker for the clock configuration block, bound to its top ports
// assumes page 0 selection and software reset seen on the register port
module adc_clock_cfg_checker
  import adc_clock_cfg_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  // watched outputs
  input wire logic [5:0] synth_int_o,
  input wire logic [13:0] synth_frac_o,
  input wire logic converter_clock_tick_o,
  input wire logic modulator_clock_tick_o,
  input wire logic [8:0] oversampling_ratio_o,
  input wire logic [8:0] dsp_instruction_count_o,
  input wire logic [4:0] dsp_decimation_o
);
  logic [7:0] page_q, page_d;
  logic [5:0] hi_q, hi_d;
  logic cpw_q, cpw_d, mpw_q, mpw_d;
  logic w0, srst;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  assign w0 = reg_wr_i && page_q == 8'h00;
  assign srst = w0 && reg_addr_i == ADDR_SW_RESET && reg_wdata_i[0];
  always_comb begin
    page_d = page_q;
    hi_d = hi_q;
    cpw_d = cpw_q;
    mpw_d = mpw_q;
    if (reg_wr_i && reg_addr_i == ADDR_PAGE) page_d = reg_wdata_i;
    if (w0 && reg_addr_i == ADDR_FRAC_HIGH) hi_d = reg_wdata_i[5:0];
    if (w0 && reg_addr_i == ADDR_CONV_DIV) cpw_d = reg_wdata_i[7];
    if (w0 && reg_addr_i == ADDR_MOD_DIV) mpw_d = reg_wdata_i[7];
    if (srst) begin
      page_d = 8'h00;
      cpw_d = 1'b0;
      mpw_d = 1'b0;
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      page_q <= 8'h00;
      hi_q <= 6'h00;
      cpw_q <= 1'b0;
      mpw_q <= 1'b0;
    end else begin
      page_q <= page_d;
      hi_q <= hi_d;
      cpw_q <= cpw_d;
      mpw_q <= mpw_d;
    end
  end
  AST_OSR_DECODE: assert property (w0 && reg_addr_i == ADDR_OSR |=>
    oversampling_ratio_o == ($past(reg_wdata_i) == 8'h00 ? 9'h100
    : {1'b0, $past(reg_wdata_i)})) else $error("osr decode wrong");
  AST_INSTR_DECODE: assert property (w0 && reg_addr_i == ADDR_INSTR_CNT |=>
    dsp_instruction_count_o == {$past(reg_wdata_i), 1'b0})
    else $error("instruction count wrong");
  AST_DECIM_DECODE: assert property (w0 && reg_addr_i == ADDR_DECIM |=>
    dsp_decimation_o == div4($past(reg_wdata_i[3:0])))
    else $error("decimation decode wrong");
  AST_INT_WRITE: assert property (w0 && reg_addr_i == ADDR_SYNTH_INT |=>
    synth_int_o == $past(reg_wdata_i[5:0])) else $error("multiplier wrong");
  AST_FRAC_LOW: assert property (w0 && reg_addr_i == ADDR_FRAC_LOW |=>
    synth_frac_o[7:0] == $past(reg_wdata_i)) else $error("fraction low wrong");
  AST_FRAC_PAIR: assert property (w0 && reg_addr_i == ADDR_FRAC_HIGH ##1
    w0 && reg_addr_i == ADDR_FRAC_LOW |=> synth_frac_o[13:8] == hi_q)
    else $error("fraction high not applied");
  AST_FRAC_HOLD: assert property (w0 && reg_addr_i == ADDR_FRAC_HIGH |=>
    $stable(synth_frac_o)) else $error("fraction high applied early");
  AST_RESET_VAL: assert property ($rose(rst_n_i) |-> ##1
    oversampling_ratio_o == 9'h080 && dsp_decimation_o == 5'h04 &&
    synth_int_o == 6'h04 && synth_frac_o == 14'h0000)
    else $error("reset values wrong");
  AST_CONV_OFF: assert property (!cpw_q [*8] |-> !converter_clock_tick_o)
    else $error("converter tick while powered down");
  AST_MOD_OFF: assert property (!mpw_q [*8] |-> !modulator_clock_tick_o)
    else $error("modulator tick while powered down");
endmodule // adc_clock_cfg_checker

bind adc_clock_cfg adc_clock_cfg_checker adc_clock_cfg_checker_inst (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .synth_int_o(synth_int_o), .synth_frac_o(synth_frac_o),
  .converter_clock_tick_o(converter_clock_tick_o),
  .modulator_clock_tick_o(modulator_clock_tick_o),
  .oversampling_ratio_o(oversampling_ratio_o),
  .dsp_instruction_count_o(dsp_instruction_count_o),
  .dsp_decimation_o(dsp_decimation_o));

// file: tb/test_adc_clock_cfg.sv
// self-checking bench for the clock configuration block
// assumes the hw/ files and the checker are compiled first
module test_adc_clock_cfg
  import adc_clock_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic mclk_i = 1'b0, bclk_i = 1'b0, synth_clk_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00;
  logic [7:0] rdata;
  logic pwr, ct, mt, st;
  logic [3:0] pre;
  logic [4:0] mr, dec;
  logic [5:0] jint;
  logic [13:0] frac;
  logic [8:0] osr, icnt;
  int n_mismatch = 0, checks = 0, cyc = 0, tc, tm, ts;
  adc_clock_cfg adc_clock_cfg_inst (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(rdata), .mclk_i(mclk_i), .bclk_i(bclk_i),
    .synth_clk_i(synth_clk_i), .synth_power_o(pwr), .synth_pre_div_o(pre),
    .synth_mult_r_o(mr), .synth_int_o(jint), .synth_frac_o(frac),
    .converter_clock_tick_o(ct), .modulator_clock_tick_o(mt),
    .sample_tick_o(st), .oversampling_ratio_o(osr),
    .dsp_instruction_count_o(icnt), .dsp_decimation_o(dec));
  always #2 core_clk_i = ~core_clk_i;
  // sources of 4, 6 and 8 cycle periods tell the selections apart
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    mclk_i <= (cyc % 4) < 2;
    bclk_i <= (cyc % 6) < 3;
    synth_clk_i <= (cyc % 8) < 4;
  end
  task automatic give_verdict();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // tick counts may be off by one with the source phase
  task automatic near(input int got, input int exp);
    checks++;
    if (got < exp - 1 || got > exp + 1) begin
      n_mismatch++;
      $display("mismatch at %0t: %0d ticks, expected %0d", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // high then low on back-to-back edges, strobe held up between them
  task automatic wr2(input logic [7:0] d7, input logic [7:0] d8);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= ADDR_FRAC_HIGH;
    reg_wdata_i <= d7;
    @(posedge core_clk_i);
    reg_addr_i <= ADDR_FRAC_LOW;
    reg_wdata_i <= d8;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    @(negedge core_clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge core_clk_i);
    chk({6'h00, rdata}, {6'h00, exp});
  endtask
  task automatic count(input int n);
    tc = 0;
    tm = 0;
    ts = 0;
    repeat (n) begin
      @(negedge core_clk_i);
      tc += int'(ct === 1'b1);
      tm += int'(mt === 1'b1);
      ts += int'(st === 1'b1);
    end
  endtask
  task automatic t_reset();
    logic [7:0] ra [8] = '{8'h06, 8'h07, 8'h08, 8'h12, 8'h13, 8'h14, 8'h15,
      8'h16};
    logic [7:0] re [8] = '{8'h04, 8'h00, 8'h00, 8'h01, 8'h01, 8'h80, 8'h80,
      8'h04};
    foreach (ra[i]) rd(ra[i], re[i]);
    chk(osr, 14'h0080);
    chk(icnt, 14'h0100);
    chk({pwr, pre, mr}, 14'h0021);
  endtask
  task automatic t_access();
    rd(8'h09, 8'h00);
    wr(8'h02, 8'h00);
    rd(8'h02, 8'h00);
    wr(ADDR_PAGE, 8'h01);
    wr(ADDR_OSR, 8'h33);
    rd(ADDR_OSR, 8'h00);
    wr(ADDR_PAGE, 8'h00);
    rd(ADDR_OSR, 8'h80);
    wr(ADDR_OSR, 8'h22);
    wr(ADDR_SW_RESET, 8'h01);
    rd(ADDR_OSR, 8'h80);
  endtask
  task automatic t_frac();
    wr2(8'h15, 8'hAA);
    chk(frac, 14'h15AA);
    wr(ADDR_FRAC_HIGH, 8'h3F);
    rd(ADDR_SYNTH_INT, 8'h04);
    wr(ADDR_FRAC_LOW, 8'h01);
    @(negedge core_clk_i);
    chk(frac, 14'h1501);
    rd(ADDR_FRAC_HIGH, 8'h15);
    wr2(8'h2A, 8'h00);
    chk(frac, 14'h2A00);
    rd(ADDR_FRAC_HIGH, 8'h2A);
    wr(ADDR_SYNTH_INT, 8'h25);
    rd(ADDR_SYNTH_INT, 8'h25);
    chk({8'h00, jint}, 14'h0025);
  endtask
  task automatic t_decode();
    logic [7:0] cs [5] = '{8'h00, 8'h01, 8'h7F, 8'hC0, 8'hFF};
    // instruction code 0 is reserved; ratios divide both settings
    logic [7:0] ic [5] = '{8'h08, 8'h01, 8'h7F, 8'hC0, 8'hFF};
    logic [3:0] dc [5] = '{4'h0, 4'h1, 4'h1, 4'h8, 4'hF};
    foreach (cs[i]) begin
      wr(ADDR_DECIM, 8'h01);
      wr(ADDR_OSR, cs[i]);
      wr(ADDR_INSTR_CNT, ic[i]);
      wr(ADDR_DECIM, {4'h0, dc[i]});
      wr(ADDR_CONV_DIV, cs[i]);
      rd(ADDR_CONV_DIV, cs[i]);
      chk(osr, cs[i] == 8'h00 ? 14'h0100 : {6'h00, cs[i]});
      chk(icnt, {5'h00, ic[i], 1'b0});
      chk(dec, dc[i] == 4'h0 ? 14'h0010 : {10'h000, dc[i]});
    end
    wr(ADDR_SYNTH_PR, 8'h80);
    @(negedge core_clk_i);
    chk({pwr, pre, mr}, 14'h0310);
  endtask
  task automatic t_chain();
    wr(ADDR_DECIM, 8'h01);
    wr(ADDR_CLK_MUX, 8'h00);
    wr(ADDR_CONV_DIV, 8'h82);
    wr(ADDR_MOD_DIV, 8'h83);
    wr(ADDR_OSR, 8'h02);
    count(240);
    near(tc, 30);
    near(tm, 10);
    near(ts, 5);
    wr(ADDR_CONV_DIV, 8'h81);
    wr(ADDR_MOD_DIV, 8'h01);
    repeat (8) @(posedge core_clk_i);
    count(100);
    near(tc, 25);
    chk(14'(tm + ts), 14'h0000);
    wr(ADDR_CONV_DIV, 8'h02);
    repeat (8) @(posedge core_clk_i);
    count(100);
    chk(14'(tc), 14'h0000);
  endtask
  task automatic t_sources();
    int e [4] = '{60, 40, 0, 30};
    wr(ADDR_SYNTH_PR, 8'h91);
    wr(ADDR_MOD_DIV, 8'h81);
    chk({pwr, pre, mr}, 14'h0221);
    wr(ADDR_OSR, 8'h01);
    wr(ADDR_CONV_DIV, 8'h81);
    foreach (e[s]) begin
      wr(ADDR_CLK_MUX, 8'(s));
      repeat (8) @(posedge core_clk_i);
      count(240);
      near(tc, e[s]);
      near(ts, e[s]);
    end
    wr(ADDR_SYNTH_PR, 8'h11);
    repeat (8) @(posedge core_clk_i);
    count(100);
    chk(14'(tc), 14'h0000);
  endtask
  initial begin
    repeat (12) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    t_reset();
    t_access();
    t_frac();
    t_decode();
    t_chain();
    t_sources();
    give_verdict();
  end
  initial begin
    repeat (30000) @(posedge core_clk_i);
    n_mismatch++;
    $display("mismatch at %0t: run timed out", $time);
    give_verdict();
  end
endmodule // test_adc_clock_cfg
